// >>> rtl/pbc_pkg.sv
// package: constants, field positions and state types for the basic control register block
package pbc_pkg;

  // addresses on the management port: the control register and this phy
  localparam logic [4:0]  CTRL_ADDR         = 5'h00;
  localparam logic [4:0]  PHY_ADDR          = 5'h01;

  // field positions of the control register
  localparam int          BIT_RESET         = 15;
  localparam int          BIT_LOOPBACK      = 14;
  localparam int          BIT_SPEED         = 13;
  localparam int          BIT_AN_ENABLE     = 12;
  localparam int          BIT_POWER_DOWN    = 11;
  localparam int          BIT_AN_RESTART    = 9;
  localparam int          BIT_DUPLEX        = 8;

  // reset value: speed 100 and auto-negotiation on, all else zero
  localparam logic        RST_SPEED         = 1'b1;
  localparam logic        RST_AN_ENABLE     = 1'b1;
  localparam logic        RST_LOOPBACK      = 1'b0;
  localparam logic        RST_POWER_DOWN    = 1'b0;
  localparam logic        RST_DUPLEX        = 1'b0;

  // duplex abilities of this phy
  localparam logic        ABLE_FULL         = 1'b1;
  localparam logic        ABLE_HALF         = 1'b1;

  // timing
  localparam int          CLK_PERIOD_NS     = 10;
  localparam int          SOFT_RESET_NS     = 10000;
  localparam int          LOOP_DEAD_NS      = 560;
  localparam logic [15:0] SOFT_RESET_CYCLES = 16'((SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] LOOP_DEAD_CYCLES  = 16'((LOOP_DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // management frame coding
  localparam logic [5:0]  PREAMBLE_BITS     = 6'h20;
  localparam logic [1:0]  OP_READ           = 2'h2;
  localparam logic [1:0]  OP_WRITE          = 2'h1;
  localparam logic [4:0]  LAST_HDR_BIT      = 5'h0B;
  localparam logic [4:0]  LAST_DATA_BIT     = 5'h0F;

  typedef enum logic [2:0] {
    PBC_IDLE  = 3'h0,
    PBC_START = 3'h1,
    PBC_HDR   = 3'h3,
    PBC_TA    = 3'h2,
    PBC_DATA  = 3'h6
  } pbc_frame_state_t;

endpackage

// >>> rtl/pbc_mgmt_serial.sv
// management port frame engine: serial frames in, register reads and write strobes out
`timescale 1ns/1ps
`default_nettype none
module pbc_mgmt_serial (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // management pins
  input  wire logic        mgmt_clk_pin,
  input  wire logic        mgmt_data_in,
  output var  logic        mgmt_data_out,
  output var  logic        mgmt_data_oe_n,
  // register side
  input  wire logic        busy,
  input  wire logic [15:0] rd_data,
  output var  logic [4:0]  reg_addr,
  output var  logic [15:0] wr_data,
  output var  logic        wr_stb
);

  logic                      mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic                      rise;
  pbc_pkg::pbc_frame_state_t state, next_state;
  logic [5:0]                cnt, next_cnt;
  logic [15:0]               shift, next_shift;
  logic                      op_read, next_op_read;
  logic [4:0]                next_addr;
  logic                      next_out, next_oe_n, next_wr_stb;

  assign rise    = mdc_s2 & ~mdc_s3;
  assign wr_data = shift;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_shift   = shift;
    next_op_read = op_read;
    next_addr    = reg_addr;
    next_out     = mgmt_data_out;
    next_oe_n    = mgmt_data_oe_n;
    next_wr_stb  = 1'b0;
    if (busy) begin
      next_state = pbc_pkg::PBC_IDLE;
      next_cnt   = 6'h00;
      next_oe_n  = 1'b1;
    end else if (rise) begin
      case (state)
        pbc_pkg::PBC_IDLE: begin
          if (mdio_s2) begin
            if (cnt != pbc_pkg::PREAMBLE_BITS) next_cnt = cnt + 6'h01;
          end else begin
            if (cnt == pbc_pkg::PREAMBLE_BITS) next_state = pbc_pkg::PBC_START;
            next_cnt = 6'h00;
          end
        end
        pbc_pkg::PBC_START: begin
          next_state = mdio_s2 ? pbc_pkg::PBC_HDR : pbc_pkg::PBC_IDLE;
        end
        pbc_pkg::PBC_HDR: begin
          next_shift = {shift[14:0], mdio_s2};
          if (cnt[4:0] == pbc_pkg::LAST_HDR_BIT) begin
            next_cnt     = 6'h00;
            next_op_read = (shift[10:9] == pbc_pkg::OP_READ);
            next_addr    = {shift[3:0], mdio_s2};
            // frames for another address or with a bad opcode are dropped
            if (shift[8:4] == pbc_pkg::PHY_ADDR &&
                (shift[10:9] == pbc_pkg::OP_READ || shift[10:9] == pbc_pkg::OP_WRITE))
              next_state = pbc_pkg::PBC_TA;
            else
              next_state = pbc_pkg::PBC_IDLE;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
        pbc_pkg::PBC_TA: begin
          if (cnt == 6'h00) begin
            next_cnt = 6'h01;
            if (op_read) begin
              next_oe_n = 1'b0;
              next_out  = 1'b0;
            end
          end else begin
            next_cnt   = 6'h00;
            next_state = pbc_pkg::PBC_DATA;
            if (op_read) begin
              next_out   = rd_data[15];
              next_shift = {rd_data[14:0], 1'b0};
            end
          end
        end
        pbc_pkg::PBC_DATA: begin
          if (op_read) begin
            if (cnt[4:0] == pbc_pkg::LAST_DATA_BIT) begin
              next_oe_n  = 1'b1;
              next_state = pbc_pkg::PBC_IDLE;
              next_cnt   = 6'h00;
            end else begin
              next_out   = shift[15];
              next_shift = {shift[14:0], 1'b0};
              next_cnt   = cnt + 6'h01;
            end
          end else begin
            next_shift = {shift[14:0], mdio_s2};
            if (cnt[4:0] == pbc_pkg::LAST_DATA_BIT) begin
              next_wr_stb = 1'b1;
              next_state  = pbc_pkg::PBC_IDLE;
              next_cnt    = 6'h00;
            end else begin
              next_cnt = cnt + 6'h01;
            end
          end
        end
        default: begin
          next_state = pbc_pkg::PBC_IDLE;
          next_cnt   = 6'h00;
          next_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    // pins come from the management master's timing, so two flops first
    mdc_s1  <= mgmt_clk_pin;
    mdc_s2  <= mdc_s1;
    mdio_s1 <= mgmt_data_in;
    mdio_s2 <= mdio_s1;
    if (rst) begin
      mdc_s3         <= 1'b0;
      state          <= pbc_pkg::PBC_IDLE;
      cnt            <= 6'h00;
      shift          <= 16'h0000;
      op_read        <= 1'b0;
      reg_addr       <= 5'h00;
      mgmt_data_out  <= 1'b0;
      mgmt_data_oe_n <= 1'b1;
      wr_stb         <= 1'b0;
    end else begin
      mdc_s3         <= mdc_s2;
      state          <= next_state;
      cnt            <= next_cnt;
      shift          <= next_shift;
      op_read        <= next_op_read;
      reg_addr       <= next_addr;
      mgmt_data_out  <= next_out;
      mgmt_data_oe_n <= next_oe_n;
      wr_stb         <= next_wr_stb;
    end
  end

endmodule
`default_nettype wire

// >>> rtl/pbc_control.sv
// top: basic control register of the 10/100 phy with its controls, loopback path and soft reset
`timescale 1ns/1ps
`default_nettype none
module pbc_control (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // management port pins
  input  wire logic       mgmt_clk_pin,
  input  wire logic       mgmt_data_in,
  output var  logic       mgmt_data_out,
  output var  logic       mgmt_data_oe_n,
  // configuration pins
  input  wire logic       cfg_loop_force,
  input  wire logic       cfg_loop_value,
  // auto-negotiation results and controls
  input  wire logic       an_speed_100,
  input  wire logic       an_full_duplex,
  output var  logic       an_enable,
  output var  logic       an_restart,
  // operating mode
  output var  logic       op_speed_100,
  output var  logic       op_full_duplex,
  output var  logic       power_down,
  output var  logic       loopback_active,
  output var  logic       soft_reset_busy,
  // mac nibble path
  input  wire logic [3:0] mac_txd,
  input  wire logic       mac_tx_en,
  output var  logic [3:0] mac_rxd,
  output var  logic       mac_rx_dv,
  // line nibble path
  input  wire logic [3:0] line_rxd,
  input  wire logic       line_rx_dv,
  output var  logic [3:0] line_txd,
  output var  logic       line_tx_en
);

  logic        f_loop, f_speed, f_an, f_pdown, f_duplex, f_restart;
  logic        next_loop, next_speed, next_an, next_pdown, next_duplex, next_restart;
  logic        next_busy;
  logic [15:0] rst_cnt, next_rst_cnt;
  logic [15:0] dead_cnt, next_dead_cnt;
  logic        loop_q, next_loop_q;
  logic        cfg_force_s1, cfg_force_s2, cfg_value_s1, cfg_value_s2;
  logic        loop_eff, duplex_rd;
  logic [15:0] ctrl_read, rd_data, wr_data;
  logic [4:0]  reg_addr;
  logic        wr_stb, ctrl_wr;
  logic        next_an_restart, next_speed_out, next_duplex_out, next_rx_dv, next_tx_en;
  logic [3:0]  next_rxd;

  pbc_mgmt_serial u_serial (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .mgmt_clk_pin   (mgmt_clk_pin),
    .mgmt_data_in   (mgmt_data_in),
    .mgmt_data_out  (mgmt_data_out),
    .mgmt_data_oe_n (mgmt_data_oe_n),
    .busy           (soft_reset_busy),
    .rd_data        (rd_data),
    .reg_addr       (reg_addr),
    .wr_data        (wr_data),
    .wr_stb         (wr_stb)
  );

  // a single-mode phy pins the duplex bit to the mode it has
  localparam logic ABLE_ONE_MODE = pbc_pkg::ABLE_FULL ^ pbc_pkg::ABLE_HALF;
  assign duplex_rd = (ABLE_ONE_MODE) ? pbc_pkg::ABLE_FULL : f_duplex;

  // reserved bits read zero whatever the master wrote
  assign ctrl_read = {soft_reset_busy, f_loop, f_speed, f_an, f_pdown, 1'b0, f_restart, duplex_rd, 8'h00};
  assign rd_data   = (reg_addr == pbc_pkg::CTRL_ADDR) ? ctrl_read : 16'h0000;
  assign ctrl_wr   = wr_stb && (reg_addr == pbc_pkg::CTRL_ADDR);

  // configuration wins over the register whenever it asks to
  assign loop_eff  = cfg_force_s2 ? cfg_value_s2 : f_loop;

  // register fields and soft reset sequence
  always_comb begin
    next_loop    = f_loop;
    next_speed   = f_speed;
    next_an      = f_an;
    next_pdown   = f_pdown;
    next_duplex  = f_duplex;
    next_restart = 1'b0;
    next_busy    = soft_reset_busy;
    next_rst_cnt = rst_cnt;
    if (soft_reset_busy) begin
      // fields stay at defaults until the sequence ends
      if (rst_cnt == 16'h0001) next_busy = 1'b0;
      next_rst_cnt = rst_cnt - 16'h0001;
    end else if (ctrl_wr) begin
      if (wr_data[pbc_pkg::BIT_RESET]) begin
        next_loop    = pbc_pkg::RST_LOOPBACK;
        next_speed   = pbc_pkg::RST_SPEED;
        next_an      = pbc_pkg::RST_AN_ENABLE;
        next_pdown   = pbc_pkg::RST_POWER_DOWN;
        next_duplex  = pbc_pkg::RST_DUPLEX;
        next_busy    = 1'b1;
        next_rst_cnt = pbc_pkg::SOFT_RESET_CYCLES;
      end else begin
        next_loop    = wr_data[pbc_pkg::BIT_LOOPBACK];
        next_speed   = wr_data[pbc_pkg::BIT_SPEED];
        next_an      = wr_data[pbc_pkg::BIT_AN_ENABLE];
        next_pdown   = wr_data[pbc_pkg::BIT_POWER_DOWN];
        next_duplex  = wr_data[pbc_pkg::BIT_DUPLEX];
        next_restart = wr_data[pbc_pkg::BIT_AN_RESTART];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      f_loop          <= pbc_pkg::RST_LOOPBACK;
      f_speed         <= pbc_pkg::RST_SPEED;
      f_an            <= pbc_pkg::RST_AN_ENABLE;
      f_pdown         <= pbc_pkg::RST_POWER_DOWN;
      f_duplex        <= pbc_pkg::RST_DUPLEX;
      f_restart       <= 1'b0;
      soft_reset_busy <= 1'b0;
      rst_cnt         <= 16'h0000;
    end else begin
      f_loop          <= next_loop;
      f_speed         <= next_speed;
      f_an            <= next_an;
      f_pdown         <= next_pdown;
      f_duplex        <= next_duplex;
      f_restart       <= next_restart;
      soft_reset_busy <= next_busy;
      rst_cnt         <= next_rst_cnt;
    end
  end

  // operating mode and nibble path
  always_comb begin
    next_loop_q     = loop_eff;
    next_dead_cnt   = dead_cnt;
    if (loop_eff && !loop_q)
      next_dead_cnt = pbc_pkg::LOOP_DEAD_CYCLES;
    else if (dead_cnt != 16'h0000)
      next_dead_cnt = dead_cnt - 16'h0001;
    // the restart bit reads one for a cycle and leaves one pulse behind
    next_an_restart = f_restart;
    // speed change takes effect on the next edge, well inside the allowed switch time
    next_speed_out  = f_an ? an_speed_100 : f_speed;
    if (loop_eff)
      next_duplex_out = 1'b1;
    else if (f_an)
      next_duplex_out = an_full_duplex;
    else
      next_duplex_out = duplex_rd;
    if (loop_eff) begin
      // line receive is isolated; looped data is blanked during the dead time
      next_rxd   = mac_txd;
      next_rx_dv = mac_tx_en && (dead_cnt == 16'h0000) && !(loop_eff && !loop_q);
    end else begin
      next_rxd   = line_rxd;
      next_rx_dv = line_rx_dv;
    end
    next_tx_en = mac_tx_en && !loop_eff && !f_pdown;
  end

  always_ff @(posedge ref_clk) begin
    // configuration pins are asynchronous straps
    cfg_force_s1 <= cfg_loop_force;
    cfg_force_s2 <= cfg_force_s1;
    cfg_value_s1 <= cfg_loop_value;
    cfg_value_s2 <= cfg_value_s1;
    if (rst) begin
      loop_q          <= 1'b0;
      dead_cnt        <= 16'h0000;
      an_enable       <= pbc_pkg::RST_AN_ENABLE;
      an_restart      <= 1'b0;
      op_speed_100    <= pbc_pkg::RST_SPEED;
      op_full_duplex  <= pbc_pkg::RST_DUPLEX;
      power_down      <= pbc_pkg::RST_POWER_DOWN;
      loopback_active <= 1'b0;
      mac_rxd         <= 4'h0;
      mac_rx_dv       <= 1'b0;
      line_txd        <= 4'h0;
      line_tx_en      <= 1'b0;
    end else begin
      loop_q          <= next_loop_q;
      dead_cnt        <= next_dead_cnt;
      an_enable       <= f_an;
      an_restart      <= next_an_restart;
      op_speed_100    <= next_speed_out;
      op_full_duplex  <= next_duplex_out;
      power_down      <= f_pdown;
      loopback_active <= loop_eff;
      mac_rxd         <= next_rxd;
      mac_rx_dv       <= next_rx_dv;
      line_txd        <= mac_txd;
      line_tx_en      <= next_tx_en;
    end
  end

endmodule
`default_nettype wire

// >>> verif/pbc_assertions.sv
// checker: port timing of the basic control register block
`timescale 1ns/1ps
`default_nettype none
module pbc_assertions (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // management port pins
  input wire logic       mgmt_clk_pin,
  input wire logic       mgmt_data_in,
  input wire logic       mgmt_data_out,
  input wire logic       mgmt_data_oe_n,
  // configuration and auto-negotiation
  input wire logic       cfg_loop_force,
  input wire logic       cfg_loop_value,
  input wire logic       an_speed_100,
  input wire logic       an_full_duplex,
  input wire logic       an_enable,
  input wire logic       an_restart,
  // operating mode
  input wire logic       op_speed_100,
  input wire logic       op_full_duplex,
  input wire logic       power_down,
  input wire logic       loopback_active,
  input wire logic       soft_reset_busy,
  // nibble paths
  input wire logic [3:0] mac_txd,
  input wire logic       mac_tx_en,
  input wire logic [3:0] mac_rxd,
  input wire logic       mac_rx_dv,
  input wire logic [3:0] line_rxd,
  input wire logic       line_rx_dv,
  input wire logic [3:0] line_txd,
  input wire logic       line_tx_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  logic [7:0]  loop_age;
  logic [7:0]  next_loop_age;

  // loop age saturates so long loopback runs never wrap back into the dead window
  always_comb begin
    next_busy_cnt = soft_reset_busy ? busy_cnt + 16'h1 : 16'h0;
    next_loop_age = !loopback_active ? 8'h0 : ((loop_age == 8'hFF) ? loop_age : loop_age + 8'h1);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_cnt <= 16'h0;
      loop_age <= 8'h0;
    end else begin
      busy_cnt <= next_busy_cnt;
      loop_age <= next_loop_age;
    end
  end

  a_restart_one_cycle: assert property (an_restart |=> !an_restart) else $error("restart pulse too long");
  a_reset_duration: assert property ($fell(soft_reset_busy) |-> busy_cnt == pbc_pkg::SOFT_RESET_CYCLES)
    else $error("soft reset length wrong");
  a_reset_defaults: assert property ($rose(soft_reset_busy) |-> ##2 (an_enable && !power_down && !an_restart))
    else $error("soft reset left fields set");
  a_loop_isolate: assert property (loopback_active && $past(loopback_active) |-> !line_tx_en)
    else $error("line driven in loopback");
  a_loop_echo: assert property (loopback_active && $past(loopback_active) && mac_rx_dv |-> mac_rxd == $past(mac_txd))
    else $error("loopback nibble wrong");
  a_dead_time: assert property (loopback_active && loop_age < 8'h32 |-> !mac_rx_dv) else $error("data in dead time");
  a_loop_resume: assert property (loopback_active && loop_age > 8'h46 |-> mac_rx_dv == $past(mac_tx_en))
    else $error("loopback valid wrong");
  a_line_to_mac: assert property (!loopback_active && !$past(loopback_active) && !$past(rst)
    |-> mac_rxd == $past(line_rxd) && mac_rx_dv == $past(line_rx_dv)) else $error("receive path wrong");
  a_an_speed: assert property (an_enable && $past(an_enable) && !$past(rst) |-> op_speed_100 == $past(an_speed_100))
    else $error("speed ignores negotiation");
  a_an_duplex: assert property (an_enable && $past(an_enable) && !loopback_active && !$past(loopback_active)
    && !$past(rst) |-> op_full_duplex == $past(an_full_duplex)) else $error("duplex ignores negotiation");
  a_loop_duplex: assert property (loopback_active && $past(loopback_active) |-> op_full_duplex)
    else $error("duplex bit used in loopback");
  a_power_quiet: assert property (power_down && $past(power_down) |-> !line_tx_en) else $error("line driven in low power");
endmodule
`default_nettype wire

// >>> verif/pbc_mgmt_master.sv
// partner: management controller clocking frames into the serial port
`timescale 1ns/1ps
`default_nettype none
module pbc_mgmt_master (
  // clock
  input  wire logic ref_clk,
  // management pins
  input  wire logic mgmt_wire,
  output var  logic mgmt_clk_pin,
  output var  logic drv_en,
  output var  logic drv_val
);
  // ref_clk cycles per clock half, well above what the synchronisers need
  localparam int HALF = 10;

  initial begin
    mgmt_clk_pin = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
  end

  // clock stands low between frames; the data line floats to its pull-up when released
  task automatic frame(input logic [1:0] op, input logic [4:0] addr, input logic [15:0] data, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'b01, op, pbc_pkg::PHY_ADDR, addr, 2'b10, data & 16'hFB00};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      drv_en = (op == pbc_pkg::OP_WRITE) || (i > 17);
      drv_val = bits[i];
      repeat (HALF) @(negedge ref_clk);
      if (i < 16) begin
        rd = {rd[14:0], mgmt_wire};
      end
      mgmt_clk_pin = 1'b1;
      repeat (HALF) @(negedge ref_clk);
      mgmt_clk_pin = 1'b0;
    end
    drv_en = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verif/phy_basic_control_register_tb.sv
// testbench: random and corner traffic through the management port and nibble paths
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_register_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        mgmt_clk_pin, mgmt_data_in, mgmt_data_out, mgmt_data_oe_n, drv_en, drv_val;
  logic        cfg_loop_force = 1'b0;
  logic        cfg_loop_value = 1'b0;
  logic        an_speed_100 = 1'b0;
  logic        an_full_duplex = 1'b0;
  logic        an_enable, an_restart, op_speed_100, op_full_duplex, power_down, loopback_active, soft_reset_busy;
  logic [3:0]  mac_txd = 4'h0;
  logic        mac_tx_en = 1'b0;
  logic [3:0]  line_rxd = 4'h0;
  logic        line_rx_dv = 1'b0;
  logic [3:0]  mac_rxd, line_txd;
  logic        mac_rx_dv, line_tx_en;
  logic [4:0]  mode;
  logic [31:0] rnd = 32'h471D9217;
  logic [31:0] nib = 32'h471D9217;
  logic [15:0] w, rd;
  int          err_count = 0;
  int          compares = 0;
  int          restarts = 0;
  int          exp_restarts = 0;

  // pull-up on the shared data line when neither side drives
  assign mgmt_data_in = !mgmt_data_oe_n ? mgmt_data_out : (drv_en ? drv_val : 1'b1);
  assign mode = {loopback_active, op_speed_100, an_enable, power_down, op_full_duplex};

  pbc_control dut (.ref_clk, .rst, .mgmt_clk_pin, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe_n, .cfg_loop_force,
    .cfg_loop_value, .an_speed_100, .an_full_duplex, .an_enable, .an_restart, .op_speed_100, .op_full_duplex,
    .power_down, .loopback_active, .soft_reset_busy, .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv, .line_rxd,
    .line_rx_dv, .line_txd, .line_tx_en);
  pbc_mgmt_master u_mgmt (.ref_clk, .mgmt_wire(mgmt_data_in), .mgmt_clk_pin, .drv_en, .drv_val);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [4:0] exp_mode(input logic [15:0] v, input logic s, input logic d);
    return {v[14], v[12] ? s : v[13], v[12], v[11], v[14] | (v[12] ? d : v[8])};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // outputs are registered: what the design takes at one rising edge shows by the next falling edge
  task automatic check_path(input logic lb, input logic pd);
    logic [4:0] t;
    logic [4:0] tx;
    @(posedge ref_clk);
    t = lb ? {mac_tx_en, mac_txd} : {line_rx_dv, line_rxd};
    tx = {mac_tx_en && !lb && !pd, mac_txd};
    @(negedge ref_clk);
    check(16'({mac_rx_dv, mac_rxd}), 16'(t));
    check(16'({line_tx_en, line_txd}), 16'(tx));
  endtask

  initial forever #5 ref_clk = ~ref_clk;

  always @(negedge ref_clk) begin
    nib = lfsr(nib);
    {mac_tx_en, mac_txd, line_rx_dv, line_rxd} = nib[9:0];
  end

  always @(posedge ref_clk) begin
    if (an_restart === 1'b1) begin
      restarts++;
    end
  end

  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(16'(mode), 16'(exp_mode(16'h3000, an_speed_100, an_full_duplex)));
    u_mgmt.frame(pbc_pkg::OP_READ, pbc_pkg::CTRL_ADDR, 16'h0000, rd);
    check(rd, 16'h3000);
    u_mgmt.frame(pbc_pkg::OP_READ, 5'h1F, 16'h0000, rd);
    check(rd, 16'h0000);
    // first pass forces 10 Mbps full duplex, the rest are random field mixes
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      w = (i == 0) ? 16'h0100 : rnd[15:0] & 16'h7B00;
      an_speed_100 = rnd[16];
      an_full_duplex = rnd[17];
      exp_restarts += int'(w[9]);
      u_mgmt.frame(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_ADDR, w, rd);
      repeat (70) @(negedge ref_clk);
      check(16'(mode), 16'(exp_mode(w, an_speed_100, an_full_duplex)));
      check_path(w[14], w[11]);
      u_mgmt.frame(pbc_pkg::OP_READ, pbc_pkg::CTRL_ADDR, 16'h0000, rd);
      check(rd, w & 16'h7900);
    end
    for (int i = 0; i < 2; i++) begin
      w = (i == 0) ? 16'h1000 : 16'h5000;
      u_mgmt.frame(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_ADDR, w, rd);
      cfg_loop_force = 1'b1;
      cfg_loop_value = (i == 0);
      repeat (70) @(negedge ref_clk);
      check(16'(loopback_active), 16'(i == 0));
      check_path(i == 0, 1'b0);
    end
    cfg_loop_force = 1'b0;
    u_mgmt.frame(pbc_pkg::OP_WRITE, pbc_pkg::CTRL_ADDR, 16'h8800, rd);
    check(16'(soft_reset_busy), 16'h0001);
    // a frame sent while busy is refused, so the line stays at its pull-up
    u_mgmt.frame(pbc_pkg::OP_READ, pbc_pkg::CTRL_ADDR, 16'h0000, rd);
    check(rd, 16'hFFFF);
    for (int n = 0; soft_reset_busy !== 1'b0; n++) begin
      if (n == 2000) begin
        err_count++;
        give_verdict();
      end
      @(negedge ref_clk);
    end
    u_mgmt.frame(pbc_pkg::OP_READ, pbc_pkg::CTRL_ADDR, 16'h0000, rd);
    check(rd, 16'h3000);
    check(16'(restarts), 16'(exp_restarts));
    give_verdict();
  end
endmodule

bind pbc_control pbc_assertions u_chk (.ref_clk, .rst, .mgmt_clk_pin, .mgmt_data_in, .mgmt_data_out, .mgmt_data_oe_n,
  .cfg_loop_force, .cfg_loop_value, .an_speed_100, .an_full_duplex, .an_enable, .an_restart, .op_speed_100,
  .op_full_duplex, .power_down, .loopback_active, .soft_reset_busy, .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv,
  .line_rxd, .line_rx_dv, .line_txd, .line_tx_en);
`default_nettype wire
